/* core/stc_pkg.sv */
package stc_pkg;

    // ----------------------------------------
    // Counter values
    // ----------------------------------------
    localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] OC_RESET   = 16'h8000;

    // ----------------------------------------
    // Register word indices (byte address / 4)
    // ----------------------------------------
    localparam logic [5:0] IDX_CHR      = 6'h00;
    localparam logic [5:0] IDX_CLR      = 6'h01;
    localparam logic [5:0] IDX_ALT_COUNTER_HIGH_BYTE     = 6'h02;
    localparam logic [5:0] IDX_ALT_COUNTER_LOW_BYTE     = 6'h03;
    localparam logic [5:0] IDX_CTRL1    = 6'h04;
    localparam logic [5:0] IDX_CTRL2    = 6'h05;
    localparam logic [5:0] IDX_STATUS   = 6'h06;
    localparam logic [5:0] IDX_IC1H     = 6'h07;
    localparam logic [5:0] IDX_IC1L     = 6'h08;
    localparam logic [5:0] IDX_IC2H     = 6'h09;
    localparam logic [5:0] IDX_IC2L     = 6'h0A;
    localparam logic [5:0] IDX_OC1H     = 6'h0B;
    localparam logic [5:0] IDX_OC1L     = 6'h0C;
    localparam logic [5:0] IDX_OC2H     = 6'h0D;
    localparam logic [5:0] IDX_OC2L     = 6'h0E;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h0F;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h10;

    // ----------------------------------------
    // Clock select encodings and prescale masks
    // ----------------------------------------
    localparam logic [1:0] CS_DIV4 = 2'h0;
    localparam logic [1:0] CS_DIV2 = 2'h1;
    localparam logic [1:0] CS_DIV8 = 2'h2;
    localparam logic [1:0] CS_EXT  = 2'h3;
    localparam logic [2:0] PRE_MASK_DIV2 = 3'h1;
    localparam logic [2:0] PRE_MASK_DIV4 = 3'h3;
    localparam logic [2:0] PRE_MASK_DIV8 = 3'h7;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic       pwm_mode;
        logic       one_pulse;
        logic       edge2_rise;
        logic       oc2_en;
        logic       oc1_en;
        logic       ext_rise;
        logic [1:0] clock_select_bits;
    } stc_ctrl2_t;

    typedef struct packed {
        logic olvl2;
        logic olvl1;
        logic edge1_rise;
    } stc_ctrl1_t;

    typedef struct packed {
        logic icf1;
        logic ocf1;
        logic overflow_flag;
        logic icf2;
        logic ocf2;
    } stc_flags_t;

    localparam stc_ctrl2_t CTRL2_RST = 8'h00;
    localparam stc_ctrl1_t CTRL1_RST = 3'h0;
    localparam stc_flags_t FLAGS_RST = 5'h00;

endpackage : stc_pkg

/* core/stc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic [1:0] clock_select_bits,
    input  wire logic       ext_rise,
    input  wire logic       restart,
    // Synchronised external count input
    input  wire logic       ext_level,
    // Counter advance
    output logic            tick
);

    logic [2:0] pre_reg;
    logic [2:0] pre_next;
    logic       ext_prev_reg;
    logic [2:0] mask;
    logic       ext_edge;

    always_comb
    begin
        unique case (clock_select_bits)
            stc_pkg::CS_DIV2: mask = stc_pkg::PRE_MASK_DIV2;
            stc_pkg::CS_DIV8: mask = stc_pkg::PRE_MASK_DIV8;
            default:          mask = stc_pkg::PRE_MASK_DIV4;
        endcase
        ext_edge = ext_rise ? (ext_level & ~ext_prev_reg)
                            : (~ext_level & ext_prev_reg);
        if (clock_select_bits == stc_pkg::CS_EXT)
            tick = ext_edge;
        else
            tick = ((pre_reg & mask) == mask);
        pre_next = restart ? 3'h0 : pre_reg + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg      <= 3'h0;
            ext_prev_reg <= 1'b1;
        end
        else
        begin
            pre_reg      <= pre_next;
            ext_prev_reg <= ext_level;
        end
    end

endmodule : stc_prescaler
`default_nettype wire

/* core/stc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_sync #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q_sync
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    if (W < 1)
    begin : g_bad_width
        $error("stc_sync: width must be at least one");
    end

    // Idle pins read as high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= '1;
            sync_reg <= '1;
        end
        else
        begin
            meta_reg <= d_async;
            sync_reg <= meta_reg;
        end
    end

    assign q_sync = sync_reg;

endmodule : stc_sync
`default_nettype wire

/* core/stc_timer.sv */
//Contract
// - 16-bit free-running up-counter advanced by prescaler; only reload is FFFCh.
// - Internal prescaler divides CPU clock by two, four or eight.
// - Clock source and ratio come from control register two select bits.
// - Two compare channels, each with 16-bit register, flag, maskable irq.
// - Two capture channels, each with register, edge select, flag, irq.
// - PWM mode and one pulse mode run on the same counter.
// - Input on a pin not bonded out is always sampled as one.
// - Each 16-bit register is reached as high byte and low byte.
// - Main and alternate words show same count; alternate low keeps flag.
// - Any write to main or alternate low byte loads FFFCh.
// - Counter starts at FFFCh after reset and in PWM and one pulse.
// - Two instances share nothing and count in lockstep after reset.
// - High byte read first buffers low byte until low byte is read.
// - Rollover from FFFFh to 0000h sets overflow flag in every mode.
// - Overflow flag clears after status read seeing it, then low access.
// - External input clocks counter when both select bits are one.
`timescale 1ns/1ps
`default_nettype none
module stc_timer #(
    parameter bit BOND_EXT = 1'b1,
    parameter bit BOND_IC1 = 1'b1,
    parameter bit BOND_IC2 = 1'b1
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic        ext_count_input,
    input  wire logic        capture_input_one,
    input  wire logic        capture_input_two,
    output logic             compare_output_one,
    output logic             compare_output_two,
    output logic             compare_oe_one,
    output logic             compare_oe_two,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [2:0]          pin_raw;
    logic [2:0]          pin_s;
    logic                tick;
    logic                restart;

    logic [15:0]         cnt_reg,      cnt_next;
    logic [15:0]         snap_reg,     snap_next;
    logic [7:0]          buf_reg,      buf_next;
    logic                buf_vld_reg,  buf_vld_next;
    stc_pkg::stc_ctrl1_t ctrl1_reg,    ctrl1_next;
    stc_pkg::stc_ctrl2_t ctrl2_reg,    ctrl2_next;
    stc_pkg::stc_flags_t flags_reg,    flags_next;
    stc_pkg::stc_flags_t arm_reg,      arm_next;
    stc_pkg::stc_flags_t istat_reg,    istat_next;
    stc_pkg::stc_flags_t imask_reg,    imask_next;
    logic [15:0]         ic1_reg,      ic1_next;
    logic [15:0]         ic2_reg,      ic2_next;
    logic [1:0]          inh_reg,      inh_next;
    logic [15:0]         oc1_reg,      oc1_next;
    logic [15:0]         oc2_reg,      oc2_next;
    logic [1:0]          out_reg,      out_next;
    logic [1:0]          oe_reg,       oe_next;
    logic [1:0]          cprev_reg;
    logic [31:0]         prdata_reg,   prdata_next;
    logic                pready_reg,   pready_next;
    logic                pslverr_reg,  pslverr_next;
    logic                irq_reg,      irq_next;

    logic                setup;
    logic                done;
    logic                rd;
    logic                wr;
    logic [5:0]          idx;
    logic                mapped;
    logic                cap1;
    logic                cap2;
    logic                m1;
    logic                m2;
    logic                ovf;
    logic [7:0]          rbyte;
    stc_pkg::stc_flags_t set_f;
    stc_pkg::stc_flags_t acc_f;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Hardware set wins over a clear in the same cycle
    function automatic stc_pkg::stc_flags_t upd_flags(
        input stc_pkg::stc_flags_t cur,
        input stc_pkg::stc_flags_t set,
        input stc_pkg::stc_flags_t clr
    );
        upd_flags = set | (cur & ~clr);
    endfunction : upd_flags

    function automatic logic edge_hit(
        input logic now,
        input logic prev,
        input logic rise
    );
        edge_hit = rise ? (now & ~prev) : (~now & prev);
    endfunction : edge_hit

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    // Unbonded inputs read as one
    assign pin_raw[0] = BOND_EXT ? ext_count_input   : 1'b1;
    assign pin_raw[1] = BOND_IC1 ? capture_input_one : 1'b1;
    assign pin_raw[2] = BOND_IC2 ? capture_input_two : 1'b1;

    stc_sync #(
        .W (3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_async (pin_raw),
        .q_sync  (pin_s)
    );

    stc_prescaler u_pre (
        .pclk              (pclk),
        .presetn           (presetn),
        .clock_select_bits (ctrl2_reg.clock_select_bits),
        .ext_rise          (ctrl2_reg.ext_rise),
        .restart           (restart),
        .ext_level         (pin_s[0]),
        .tick              (tick)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        setup  = psel & ~penable;
        done   = psel & penable & pready_reg;
        rd     = done & ~pwrite;
        wr     = done & pwrite;
        idx    = paddr[7:2];
        mapped = (paddr[1:0] == 2'h0) && (idx <= stc_pkg::IDX_IRQ_MASK);

        m1   = tick && (cnt_reg == oc1_reg);
        m2   = tick && (cnt_reg == oc2_reg);
        ovf  = tick && (cnt_reg == stc_pkg::CNT_MAX);
        cap1 = edge_hit(pin_s[1], cprev_reg[0], ctrl1_reg.edge1_rise)
               && !inh_reg[0] && !ctrl2_reg.one_pulse
               && !ctrl2_reg.pwm_mode;
        cap2 = edge_hit(pin_s[2], cprev_reg[1], ctrl2_reg.edge2_rise)
               && !inh_reg[1];

        // Counter
        cnt_next = tick ? cnt_reg + 16'h0001 : cnt_reg;
        restart  = 1'b0;
        if (ctrl2_reg.pwm_mode && m2)
        begin
            cnt_next = stc_pkg::CNT_RELOAD;
            restart  = 1'b1;
        end
        if (ctrl2_reg.one_pulse
            && edge_hit(pin_s[1], cprev_reg[0], ctrl1_reg.edge1_rise))
        begin
            cnt_next = stc_pkg::CNT_RELOAD;
            restart  = 1'b1;
        end
        if (wr && (idx == stc_pkg::IDX_CLR || idx == stc_pkg::IDX_ALT_COUNTER_LOW_BYTE))
        begin
            cnt_next = stc_pkg::CNT_RELOAD;
            restart  = 1'b1;
        end

        // Captures
        ic1_next = cap1 ? cnt_reg : ic1_reg;
        ic2_next = cap2 ? cnt_reg : ic2_reg;
        inh_next = inh_reg;
        if (rd && idx == stc_pkg::IDX_IC1H)
            inh_next[0] = 1'b1;
        if (done && idx == stc_pkg::IDX_IC1L)
            inh_next[0] = 1'b0;
        if (rd && idx == stc_pkg::IDX_IC2H)
            inh_next[1] = 1'b1;
        if (done && idx == stc_pkg::IDX_IC2L)
            inh_next[1] = 1'b0;

        // Compare outputs
        out_next = out_reg;
        if (ctrl2_reg.pwm_mode)
        begin
            if (m1)
                out_next[0] = ctrl1_reg.olvl1;
            if (m2)
                out_next[0] = ctrl1_reg.olvl2;
        end
        else if (ctrl2_reg.one_pulse)
        begin
            if (restart && !wr)
                out_next[0] = ctrl1_reg.olvl2;
            else if (m1)
                out_next[0] = ctrl1_reg.olvl1;
        end
        else
        begin
            if (m1 && ctrl2_reg.oc1_en)
                out_next[0] = ctrl1_reg.olvl1;
            if (m2 && ctrl2_reg.oc2_en)
                out_next[1] = ctrl1_reg.olvl2;
        end
        oe_next = {ctrl2_reg.oc2_en,
                   ctrl2_reg.oc1_en | ctrl2_reg.pwm_mode
                   | ctrl2_reg.one_pulse};

        // Flags: arm on status read, clear on low byte access
        set_f = '{icf1: cap1, ocf1: m1, overflow_flag: ovf,
                  icf2: cap2, ocf2: m2};
        acc_f = '{icf1: done && idx == stc_pkg::IDX_IC1L,
                  ocf1: done && idx == stc_pkg::IDX_OC1L,
                  overflow_flag: done && idx == stc_pkg::IDX_CLR,
                  icf2: done && idx == stc_pkg::IDX_IC2L,
                  ocf2: done && idx == stc_pkg::IDX_OC2L};
        flags_next = upd_flags(flags_reg, set_f, arm_reg & acc_f);
        arm_next   = (rd && idx == stc_pkg::IDX_STATUS) ? flags_reg
                                                        : arm_reg;
        arm_next   = arm_next & ~acc_f;

        // Interrupt status, cleared by its own read
        istat_next = upd_flags(istat_reg, set_f,
            (rd && idx == stc_pkg::IDX_IRQ_STAT) ? '1 : '0);
        imask_next = imask_reg;
        irq_next   = |(istat_next & imask_reg);

        // Low byte buffering for two-step read
        snap_next    = setup ? cnt_reg : snap_reg;
        buf_next     = buf_reg;
        buf_vld_next = buf_vld_reg;
        if (rd && (idx == stc_pkg::IDX_CHR || idx == stc_pkg::IDX_ALT_COUNTER_HIGH_BYTE)
            && !buf_vld_reg)
        begin
            buf_next     = snap_reg[7:0];
            buf_vld_next = 1'b1;
        end
        if (rd && (idx == stc_pkg::IDX_CLR || idx == stc_pkg::IDX_ALT_COUNTER_LOW_BYTE))
            buf_vld_next = 1'b0;

        // Register writes
        ctrl1_next = ctrl1_reg;
        ctrl2_next = ctrl2_reg;
        oc1_next   = oc1_reg;
        oc2_next   = oc2_reg;
        if (wr)
        begin
            unique case (idx)
                stc_pkg::IDX_CTRL1:    ctrl1_next = pwdata[2:0];
                stc_pkg::IDX_CTRL2:    ctrl2_next = pwdata[7:0];
                stc_pkg::IDX_OC1H:     oc1_next[15:8] = pwdata[7:0];
                stc_pkg::IDX_OC1L:     oc1_next[7:0]  = pwdata[7:0];
                stc_pkg::IDX_OC2H:     oc2_next[15:8] = pwdata[7:0];
                stc_pkg::IDX_OC2L:     oc2_next[7:0]  = pwdata[7:0];
                stc_pkg::IDX_IRQ_MASK: imask_next = pwdata[4:0];
                default:               ;
            endcase
        end

        // Read data prepared in the setup cycle
        unique case (idx)
            stc_pkg::IDX_CHR,
            stc_pkg::IDX_ALT_COUNTER_HIGH_BYTE:     rbyte = cnt_reg[15:8];
            stc_pkg::IDX_CLR,
            stc_pkg::IDX_ALT_COUNTER_LOW_BYTE:     rbyte = buf_vld_reg ? buf_reg
                                                       : cnt_reg[7:0];
            stc_pkg::IDX_CTRL1:    rbyte = {5'h00, ctrl1_reg};
            stc_pkg::IDX_CTRL2:    rbyte = ctrl2_reg;
            stc_pkg::IDX_STATUS:   rbyte = {flags_reg, 3'h0};
            stc_pkg::IDX_IC1H:     rbyte = ic1_reg[15:8];
            stc_pkg::IDX_IC1L:     rbyte = ic1_reg[7:0];
            stc_pkg::IDX_IC2H:     rbyte = ic2_reg[15:8];
            stc_pkg::IDX_IC2L:     rbyte = ic2_reg[7:0];
            stc_pkg::IDX_OC1H:     rbyte = oc1_reg[15:8];
            stc_pkg::IDX_OC1L:     rbyte = oc1_reg[7:0];
            stc_pkg::IDX_OC2H:     rbyte = oc2_reg[15:8];
            stc_pkg::IDX_OC2L:     rbyte = oc2_reg[7:0];
            stc_pkg::IDX_IRQ_STAT: rbyte = {3'h0, istat_reg};
            stc_pkg::IDX_IRQ_MASK: rbyte = {3'h0, imask_reg};
            default:               rbyte = 8'h00;
        endcase
        prdata_next  = prdata_reg;
        pslverr_next = pslverr_reg;
        if (setup)
        begin
            prdata_next  = (mapped && !pwrite) ? {24'h000000, rbyte}
                                               : 32'h00000000;
            pslverr_next = !mapped;
        end
        pready_next = setup;
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg     <= stc_pkg::CNT_RELOAD;
            snap_reg    <= stc_pkg::CNT_RELOAD;
            buf_reg     <= 8'h00;
            buf_vld_reg <= 1'b0;
            ctrl1_reg   <= stc_pkg::CTRL1_RST;
            ctrl2_reg   <= stc_pkg::CTRL2_RST;
            flags_reg   <= stc_pkg::FLAGS_RST;
            arm_reg     <= stc_pkg::FLAGS_RST;
            istat_reg   <= stc_pkg::FLAGS_RST;
            imask_reg   <= stc_pkg::FLAGS_RST;
            ic1_reg     <= 16'h0000;
            ic2_reg     <= 16'h0000;
            inh_reg     <= 2'h0;
            oc1_reg     <= stc_pkg::OC_RESET;
            oc2_reg     <= stc_pkg::OC_RESET;
            out_reg     <= 2'h0;
            oe_reg      <= 2'h0;
            cprev_reg   <= 2'h3;
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            cnt_reg     <= cnt_next;
            snap_reg    <= snap_next;
            buf_reg     <= buf_next;
            buf_vld_reg <= buf_vld_next;
            ctrl1_reg   <= ctrl1_next;
            ctrl2_reg   <= ctrl2_next;
            flags_reg   <= flags_next;
            arm_reg     <= arm_next;
            istat_reg   <= istat_next;
            imask_reg   <= imask_next;
            ic1_reg     <= ic1_next;
            ic2_reg     <= ic2_next;
            inh_reg     <= inh_next;
            oc1_reg     <= oc1_next;
            oc2_reg     <= oc2_next;
            out_reg     <= out_next;
            oe_reg      <= oe_next;
            cprev_reg   <= pin_s[2:1];
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg     <= irq_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign compare_output_one = out_reg[0];
    assign compare_output_two = out_reg[1];
    assign compare_oe_one     = oe_reg[0];
    assign compare_oe_two     = oe_reg[1];
    assign irq                = irq_reg;

endmodule : stc_timer
`default_nettype wire

/* verification/stc_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_pins_model (
    // Clock
    input  wire logic pclk,
    // Timer pins
    output logic      ext_count_input,
    output logic      capture_input_one,
    output logic      capture_input_two
);
    // ----------------------------------------
    // Pins idle high, external edges on request
    // ----------------------------------------
    initial
    begin
        ext_count_input   = 1'b1;
        capture_input_one = 1'b1;
        capture_input_two = 1'b1;
    end

    task automatic toggle(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ext_count_input <= ~ext_count_input;
            repeat (5) @(posedge pclk);
        end
    endtask : toggle

    // Falling then rising edge on capture input two
    task automatic pulse_two;
        @(posedge pclk);
        capture_input_two <= 1'b0;
        repeat (5) @(posedge pclk);
        capture_input_two <= 1'b1;
    endtask : pulse_two
endmodule : stc_pins_model
`default_nettype wire

/* verification/stc_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_timer_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // ----------------------------------------
    // Register bus answers
    // ----------------------------------------
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_only: assert property (!(psel && !penable) |=> !pready)
        else $error("pready without setup");
    chk_err_align: assert property
        (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned access not refused");
    chk_err_range: assert property (psel && !penable && paddr > 8'h40
        |=> pslverr && pready)
        else $error("unmapped access not refused");
    chk_ok_mapped: assert property (psel && !penable && paddr <= 8'h40
        && paddr[1:0] == 2'h0 |=> pready && !pslverr)
        else $error("mapped access refused");
    chk_err_data: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data on refused access");
    chk_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_data_hold: assert property (!(psel && !penable)
        |=> $stable(prdata))
        else $error("read data changed without setup");
endmodule : stc_timer_monitor

bind stc_timer stc_timer_monitor stc_timer_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

/* verification/stc_timer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_timer_test;
    localparam logic [1:0] CS_TAB [3] = '{stc_pkg::CS_DIV2,
        stc_pkg::CS_DIV4, stc_pkg::CS_DIV8};
    localparam int DIV_TAB [3] = '{2, 4, 8};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        irq, ext_in, cap1, cap2, err, lvl;
    logic        oc1, oc2, oe1, oe2;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] v1, v2;
    int          n_mismatch, comparisons, k, n;

    stc_timer stc_timer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_count_input(ext_in),
        .capture_input_one(cap1), .capture_input_two(cap2),
        .compare_output_one(oc1), .compare_output_two(oc2),
        .compare_oe_one(oe1), .compare_oe_two(oe2), .irq(irq));
    stc_pins_model stc_pins_model_inst (.pclk(pclk),
        .ext_count_input(ext_in), .capture_input_one(cap1),
        .capture_input_two(cap2));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic end_sim;
        $display("Mismatches %0d, compares %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            end_sim();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        apb(1'b0, a, 32'h0);
        v[15:8] = rd[7:0];
        apb(1'b0, a + 8'h04, 32'h0);
        v[7:0] = rd[7:0];
    endtask : rd16

    function automatic logic [15:0] edges(logic l, logic rise, int cnt);
        return 16'((cnt + ((rise ? !l : l) ? 1 : 0)) / 2);
    endfunction : edges

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        void'($urandom(32'h2CA1));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        check("ctrl2 reset", rd, 32'h0);
        apb(1'b1, 8'h14, {30'h0, stc_pkg::CS_EXT});
        apb(1'b1, 8'h40, 32'h4);
        apb(1'b0, 8'h3C, 32'h0);
        apb(1'b1, 8'h0C, $urandom);
        rd16(8'h00, v1);
        check("count", v1, stc_pkg::CNT_RELOAD);
        rd16(8'h08, v1);
        check("alt count", v1, stc_pkg::CNT_RELOAD);
        stc_pins_model_inst.toggle(6);
        apb(1'b0, 8'h00, 32'h0);
        check("high", rd, 32'hFF);
        stc_pins_model_inst.toggle(2);
        apb(1'b0, 8'h00, 32'h0);
        check("high wrap", rd, 32'h00);
        apb(1'b0, 8'h04, 32'h0);
        check("low buffered", rd, 32'hFF);
        apb(1'b0, 8'h04, 32'h0);
        check("low live", rd, 32'h00);
        repeat (2) @(posedge pclk);
        check("irq", irq, 1'b1);
        for (k = 0; k < 3; k++)
        begin
            apb(1'b0, (k == 2) ? 8'h04 : 8'h18, 32'h0);
            apb(1'b0, 8'h18, 32'h0);
            check("status", rd, (k == 2) ? 32'h0 : 32'h20);
            apb(1'b0, 8'h0C, 32'h0);
        end
        apb(1'b0, 8'h3C, 32'h0);
        check("irq status", rd, 32'h4);
        repeat (2) @(posedge pclk);
        check("irq clear", irq, 1'b0);
        for (k = 0; k < 2; k++)
        begin
            apb(1'b0, k[0] ? 8'h05 : 8'h44, 32'h0);
            check("slverr", err, 1'b1);
            apb(1'b1, 8'h14, {29'h0, k[0], stc_pkg::CS_EXT});
            apb(1'b1, 8'h04, $urandom);
            n = $urandom_range(9, 1);
            lvl = ext_in;
            stc_pins_model_inst.toggle(n);
            rd16(8'h00, v1);
            v2 = stc_pkg::CNT_RELOAD + edges(lvl, k[0], n);
            check("ext", v1, v2);
        end
        for (k = 0; k < 3; k++)
        begin
            apb(1'b1, 8'h14, {30'h0, CS_TAB[k]});
            n = 8 * $urandom_range(3);
            rd16(8'h00, v1);
            repeat (n + 2) @(posedge pclk);
            rd16(8'h00, v2);
            check("ticks", 16'(v2 - v1), (n + 8) / DIV_TAB[k]);
        end
        // Compare channel one drives its pin, then a capture on two
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h2C, 32'h0);
        apb(1'b1, 8'h30, 32'h10);
        apb(1'b1, 8'h04, $urandom);
        apb(1'b1, 8'h14, 32'h9);
        check("oc1 idle", oc1, 1'b0);
        repeat (64) @(posedge pclk);
        check("oc1 match", oc1, 1'b1);
        check("oe oc2", {oe2, oe1, oc2}, 3'h2);
        stc_pins_model_inst.pulse_two();
        apb(1'b0, 8'h18, 32'h0);
        check("flags oc1 ic2", {rd[6], rd[4]}, 2'h3);
        end_sim();
    end
endmodule : stc_timer_test
`default_nettype wire
